// ---- src/ctb_regs.sv ----
// tie-off override, bias control, level readout and automute status registers
//
// Contract
// - tie-off force bits act only when override set
// - left line tie-off follows its force bit
// - left inverting amp tie-off follows its bit
// - left non-inverting amp tie-off follows its bit
// - half-bias bit halves input stage bias
// - raise bit adds fixed bias increment
// - lower bit subtracts fixed bias amount
// - bypass force closes switch while buffer disabled
// - ground force closes switch while buffer disabled
// - high-ohm reference switch forced or power-managed
// - mid-ohm reference switch forced or power-managed
// - low-ohm reference switch forced or power-managed
// - peak-to-peak readout reports larger controlled channel
// - peak detector readout reports larger controlled channel
// - automute source select drives observation point
// - status bit reports speaker supply high detector
// - status bit reports noise gate holding gain
//
// The implementer's own choice: register access over Wishbone.
`timescale 1ns/10ps
module ctb_regs (
   input  wire logic                       clk_i,
   input  wire logic                       rst_i,
   input  wire logic                       wb_cyc_i,
   input  wire logic                       wb_stb_i,
   input  wire logic                       wb_we_i,
   input  wire logic [ctb_pkg::ADR_W-1:0]  wb_adr_i,
   input  wire logic [3:0]                 wb_sel_i,
   input  wire logic [31:0]                wb_dat_i,
   output logic      [31:0]                wb_dat_o,
   output logic                            wb_ack_o,
   input  wire ctb_pkg::ctb_alc_s          alc_left_i,
   input  wire ctb_pkg::ctb_alc_s          alc_right_i,
   input  wire logic                       noise_gate_active_flag_i,
   input  wire logic                       speaker_supply_high_flag_i,
   input  wire logic                       auto_left_line_tieoff_i,
   input  wire logic                       auto_left_inv_tieoff_i,
   input  wire logic                       auto_left_noninv_tieoff_i,
   input  wire logic                       input_buffer_enabled_i,
   input  wire logic                       auto_buffer_bypass_i,
   input  wire logic                       auto_buffer_ground_i,
   input  wire logic [2:0]                 pm_ref_ground_i,
   output logic                            left_line_tieoff_o,
   output logic                            left_inv_tieoff_o,
   output logic                            left_noninv_tieoff_o,
   output logic                            input_stage_bias_half_o,
   output logic                            input_stage_bias_raise_o,
   output logic                            input_stage_bias_lower_o,
   output logic                            input_buffer_bypass_o,
   output logic                            input_buffer_ground_o,
   output logic [2:0]                      ref_ground_o,
   output logic                            automute_source_select_o,
   output logic                            irq_o
);

   ctb_pkg::ctb_tie_s         tie_q;
   ctb_pkg::ctb_bias_s        bias_q;
   logic                      amute_sel_q;
   logic [8:0]                p2p_q;
   logic [8:0]                peak_q;
   logic                      hv_meta_q;
   logic                      hv_sync_q;
   logic                      hv_prev_q;
   logic                      gate_prev_q;
   logic                      ack_q;
   logic [31:0]               rd_q;
   logic [31:0]               rd_d;
   logic [7:0]                idx;
   logic                      req;
   logic                      wr;
   logic [8:0]                wmask;
   logic [8:0]                wdat;
   logic [8:0]                amute_word;
   logic [ctb_pkg::EV_W-1:0]  events;
   logic [ctb_pkg::EV_W-1:0]  irq_status;
   logic [ctb_pkg::EV_W-1:0]  irq_mask;
   logic [ctb_pkg::EV_W-1:0]  irq_clr;

   // bus decode: one access per request, answered one cycle later
   assign idx   = wb_adr_i[ctb_pkg::ADR_W-1:2];
   assign req   = wb_cyc_i & wb_stb_i & ~ack_q;
   assign wr    = req & wb_we_i;
   assign wmask = {wb_sel_i[1], {8{wb_sel_i[0]}}};
   assign wdat  = wb_dat_i[8:0];
   assign irq_clr = (wr && idx == ctb_pkg::IDX_IRQ_STAT && wb_sel_i[0])
                  ? wb_dat_i[ctb_pkg::EV_W-1:0] : '0;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_q <= 1'b0;
      end else begin
         ack_q <= req;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         tie_q <= ctb_pkg::TIE_RST;
      end else if (wr && idx == ctb_pkg::IDX_TIEOFF) begin
         tie_q <= (tie_q & ~(wmask & ctb_pkg::TIE_WR_MASK))
                | (wdat & wmask & ctb_pkg::TIE_WR_MASK);
      end
   end

   // reserved bit is never stored
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         bias_q <= ctb_pkg::BIAS_RST;
      end else if (wr && idx == ctb_pkg::IDX_BIAS) begin
         bias_q <= (bias_q & ~(wmask & ctb_pkg::BIAS_WR_MASK))
                 | (wdat & wmask & ctb_pkg::BIAS_WR_MASK);
      end
   end

   // only the select bit of the status word is writable
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         amute_sel_q <= ctb_pkg::AMUTE_RST;
      end else if (wr && idx == ctb_pkg::IDX_AMUTE && wmask[ctb_pkg::AMUTE_SEL_BIT]) begin
         amute_sel_q <= wdat[ctb_pkg::AMUTE_SEL_BIT];
      end
   end

   // level readouts: larger channel when both are under control
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         p2p_q  <= 9'h000;
         peak_q <= 9'h000;
      end else if (alc_left_i.on && alc_right_i.on) begin
         p2p_q  <= (alc_left_i.p2p >= alc_right_i.p2p) ? alc_left_i.p2p
                                                       : alc_right_i.p2p;
         peak_q <= (alc_left_i.peak >= alc_right_i.peak) ? alc_left_i.peak
                                                         : alc_right_i.peak;
      end else if (alc_right_i.on) begin
         p2p_q  <= alc_right_i.p2p;
         peak_q <= alc_right_i.peak;
      end else begin
         p2p_q  <= alc_left_i.p2p;
         peak_q <= alc_left_i.peak;
      end
   end

   // supply detector comes from the analog side
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         hv_meta_q <= 1'b0;
         hv_sync_q <= 1'b0;
      end else begin
         hv_meta_q <= speaker_supply_high_flag_i;
         hv_sync_q <= hv_meta_q;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         hv_prev_q   <= 1'b0;
         gate_prev_q <= 1'b0;
      end else begin
         hv_prev_q   <= hv_sync_q;
         gate_prev_q <= noise_gate_active_flag_i;
      end
   end

   always_comb begin
      events                         = '0;
      events[ctb_pkg::EV_HV_RISE]  = hv_sync_q & ~hv_prev_q;
      events[ctb_pkg::EV_HV_FALL]  = ~hv_sync_q & hv_prev_q;
      events[ctb_pkg::EV_GATE_ON]  = noise_gate_active_flag_i & ~gate_prev_q;
      events[ctb_pkg::EV_GATE_OFF] = ~noise_gate_active_flag_i & gate_prev_q;
   end

   ctb_irq u_irq (
      .clk_i     (clk_i),
      .rst_i     (rst_i),
      .event_i   (events),
      .clr_wr_i  (wr && idx == ctb_pkg::IDX_IRQ_STAT && wb_sel_i[0]),
      .mask_wr_i (wr && idx == ctb_pkg::IDX_IRQ_MASK && wb_sel_i[0]),
      .wr_data_i (wb_dat_i[ctb_pkg::EV_W-1:0]),
      .status_o  (irq_status),
      .mask_o    (irq_mask),
      .irq_o     (irq_o)
   );

   always_comb begin
      amute_word                         = 9'h000;
      amute_word[ctb_pkg::AMUTE_SEL_BIT] = amute_sel_q;
      amute_word[ctb_pkg::HV_BIT]        = hv_sync_q;
      amute_word[ctb_pkg::GATE_BIT]      = noise_gate_active_flag_i;
   end

   // read mux; unmapped indices read zero
   always_comb begin
      rd_d = ctb_pkg::RD_RST;
      unique case (idx)
         ctb_pkg::IDX_TIEOFF:   rd_d[8:0] = tie_q & ctb_pkg::TIE_WR_MASK;
         ctb_pkg::IDX_BIAS:     rd_d[8:0] = bias_q & ctb_pkg::BIAS_WR_MASK;
         ctb_pkg::IDX_P2P:      rd_d[8:0] = p2p_q;
         ctb_pkg::IDX_PEAK:     rd_d[8:0] = peak_q;
         ctb_pkg::IDX_AMUTE:    rd_d[8:0] = amute_word;
         ctb_pkg::IDX_IRQ_STAT: rd_d[ctb_pkg::EV_W-1:0] = irq_status;
         ctb_pkg::IDX_IRQ_MASK: rd_d[ctb_pkg::EV_W-1:0] = irq_mask;
         default:               rd_d = ctb_pkg::RD_RST;
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         rd_q <= ctb_pkg::RD_RST;
      end else if (req && !wb_we_i) begin
         rd_q <= rd_d;
      end else if (!req) begin
         rd_q <= ctb_pkg::RD_RST;
      end
   end

   assign wb_ack_o = ack_q;
   assign wb_dat_o = rd_q;

   // input tie-off switches: manual force or automatic control
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         left_line_tieoff_o   <= 1'b0;
         left_inv_tieoff_o    <= 1'b0;
         left_noninv_tieoff_o <= 1'b0;
      end else if (tie_q.input_tieoff_override_enable) begin
         left_line_tieoff_o   <= tie_q.force_left_line_tieoff;
         left_inv_tieoff_o    <= tie_q.force_left_inv_amp_tieoff;
         left_noninv_tieoff_o <= tie_q.force_left_noninv_amp_tieoff;
      end else begin
         left_line_tieoff_o   <= auto_left_line_tieoff_i;
         left_inv_tieoff_o    <= auto_left_inv_tieoff_i;
         left_noninv_tieoff_o <= auto_left_noninv_tieoff_i;
      end
   end

   // bias trims go straight to the analog bias generator
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         input_stage_bias_half_o  <= 1'b0;
         input_stage_bias_raise_o <= 1'b0;
         input_stage_bias_lower_o <= 1'b0;
      end else begin
         input_stage_bias_half_o  <= bias_q.input_stage_bias_half;
         input_stage_bias_raise_o <= bias_q.input_stage_bias_raise;
         input_stage_bias_lower_o <= bias_q.input_stage_bias_lower;
      end
   end

   // buffer switches: force applies only while the buffer amp is off
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         input_buffer_bypass_o <= 1'b0;
         input_buffer_ground_o <= 1'b0;
      end else begin
         input_buffer_bypass_o <= (bias_q.input_buffer_bypass_force && !input_buffer_enabled_i)
                                | auto_buffer_bypass_i;
         input_buffer_ground_o <= (bias_q.input_buffer_ground_force && !input_buffer_enabled_i)
                                | auto_buffer_ground_i;
      end
   end

   // reference ground switches: [2] high, [1] mid, [0] low value path
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ref_ground_o <= 3'h0;
      end else begin
         ref_ground_o[2] <= bias_q.ref_high_ohm_ground_force | pm_ref_ground_i[2];
         ref_ground_o[1] <= bias_q.ref_mid_ohm_ground_force | pm_ref_ground_i[1];
         ref_ground_o[0] <= bias_q.ref_low_ohm_ground_force | pm_ref_ground_i[0];
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         automute_source_select_o <= 1'b0;
      end else begin
         automute_source_select_o <= amute_sel_q;
      end
   end

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   bus_ack_once_a: assert property (req |=> wb_ack_o ##1 !wb_ack_o)
      else $error("ack not a single pulse after request");

   tie_override_a: assert property (
      tie_q.input_tieoff_override_enable |=>
         left_line_tieoff_o == $past(tie_q.force_left_line_tieoff))
      else $error("override ignored on line tie-off");

   tie_auto_a: assert property (
      !tie_q.input_tieoff_override_enable |=>
         left_line_tieoff_o == $past(auto_left_line_tieoff_i))
      else $error("automatic line tie-off not followed");

   tie_inv_a: assert property (
      tie_q.input_tieoff_override_enable |=>
         left_inv_tieoff_o == $past(tie_q.force_left_inv_amp_tieoff))
      else $error("inverting tie-off wrong");

   tie_noninv_a: assert property (
      tie_q.input_tieoff_override_enable |=>
         left_noninv_tieoff_o == $past(tie_q.force_left_noninv_amp_tieoff))
      else $error("non-inverting tie-off wrong");

   bias_write_a: assert property (
      (wr && idx == ctb_pkg::IDX_BIAS && &wb_sel_i[1:0]) |=>
         ##1 {input_stage_bias_half_o, input_stage_bias_raise_o, input_stage_bias_lower_o}
            == {$past(wdat[8], 2), $past(wdat[6], 2), $past(wdat[5], 2)})
      else $error("bias trims do not follow write");

   bias_hold_a: assert property (
      $stable(bias_q) |=> $stable({input_stage_bias_raise_o, input_stage_bias_lower_o}))
      else $error("bias trim moved without write");

   bypass_force_a: assert property (
      (bias_q.input_buffer_bypass_force && !input_buffer_enabled_i) |=> input_buffer_bypass_o)
      else $error("bypass switch not forced closed");

   ground_force_a: assert property (
      (bias_q.input_buffer_ground_force && !input_buffer_enabled_i) |=> input_buffer_ground_o)
      else $error("ground switch not forced closed");

   vref_high_a: assert property (
      bias_q.ref_high_ohm_ground_force |=> ref_ground_o[2])
      else $error("high-ohm reference switch not forced");

   vref_pm_a: assert property (
      (bias_q[2:0] == 3'h0) |=> ref_ground_o == $past(pm_ref_ground_i))
      else $error("reference switches ignore power setting");

   p2p_max_a: assert property (
      (alc_left_i.on && alc_right_i.on) |=>
         p2p_q >= $past(alc_left_i.p2p) && p2p_q >= $past(alc_right_i.p2p))
      else $error("peak-to-peak readout not the larger value");

   peak_max_a: assert property (
      (alc_left_i.on && alc_right_i.on) |=>
         peak_q >= $past(alc_left_i.peak) && peak_q >= $past(alc_right_i.peak))
      else $error("peak readout not the larger value");

   hv_read_a: assert property (
      (req && !wb_we_i && idx == ctb_pkg::IDX_AMUTE) |=>
         wb_dat_o[ctb_pkg::HV_BIT] == $past(hv_sync_q)
         && wb_dat_o[ctb_pkg::GATE_BIT] == $past(noise_gate_active_flag_i))
      else $error("status bits read wrong");

   ro_write_a: assert property (
      (wr && idx == ctb_pkg::IDX_AMUTE) |=>
         wb_dat_o == ctb_pkg::RD_RST)
      else $error("write returned data");

   rsvd_read_a: assert property (
      (req && !wb_we_i) |=> wb_dat_o[31:9] == 23'h00_0000 && !(
         $past(idx) == ctb_pkg::IDX_BIAS && wb_dat_o[7]))
      else $error("reserved bits read nonzero");

   irq_level_a: assert property (
      ##1 irq_o == |((($past(irq_status) & ~$past(irq_clr)) | $past(events)) & $past(irq_mask)))
      else $error("interrupt level mismatch");

   tie_write_c: cover property (wr && idx == ctb_pkg::IDX_TIEOFF ##2 left_line_tieoff_o);
   both_on_c:   cover property (alc_left_i.on && alc_right_i.on ##1 p2p_q != 9'h000);
   irq_c:       cover property (!irq_o ##1 irq_o);
   hv_rise_c:   cover property (events[ctb_pkg::EV_HV_RISE]);

endmodule : ctb_regs

// ---- include/ctb_pkg.sv ----
// constants and carrier types for the tie-off, bias and status register slice
package ctb_pkg;

   localparam int unsigned DW      = 9;
   localparam int unsigned ADR_W   = 10;
   localparam int unsigned EV_W    = 4;
   localparam int unsigned RD_W    = 32;

   // register indices; byte address is four times the index
   localparam logic [7:0] IDX_TIEOFF   = 8'h4a;
   localparam logic [7:0] IDX_BIAS     = 8'h4b;
   localparam logic [7:0] IDX_P2P      = 8'h4c;
   localparam logic [7:0] IDX_PEAK     = 8'h4d;
   localparam logic [7:0] IDX_AMUTE    = 8'h4e;
   localparam logic [7:0] IDX_IRQ_STAT = 8'h50;
   localparam logic [7:0] IDX_IRQ_MASK = 8'h51;

   // writable bits of each register
   localparam logic [8:0] TIE_WR_MASK   = 9'h107;
   localparam logic [8:0] BIAS_WR_MASK  = 9'h17f;
   localparam logic [8:0] AMUTE_WR_MASK = 9'h020;

   // field positions in the automute select and status word
   localparam int unsigned AMUTE_SEL_BIT = 5;
   localparam int unsigned HV_BIT        = 4;
   localparam int unsigned GATE_BIT      = 3;

   // event positions in the interrupt status and mask words
   localparam int unsigned EV_HV_RISE   = 0;
   localparam int unsigned EV_HV_FALL   = 1;
   localparam int unsigned EV_GATE_ON   = 2;
   localparam int unsigned EV_GATE_OFF  = 3;

   localparam logic [8:0]  TIE_RST   = 9'h000;
   localparam logic [8:0]  BIAS_RST  = 9'h000;
   localparam logic        AMUTE_RST = 1'b0;
   localparam logic [3:0]  MASK_RST  = 4'h0;
   localparam logic [3:0]  STAT_RST  = 4'h0;
   localparam logic [31:0] RD_RST    = 32'h0000_0000;

   typedef struct packed {
      logic       input_tieoff_override_enable;
      logic [4:0] unused_right;
      logic       force_left_line_tieoff;
      logic       force_left_inv_amp_tieoff;
      logic       force_left_noninv_amp_tieoff;
   } ctb_tie_s;

   typedef struct packed {
      logic input_stage_bias_half;
      logic rsvd;
      logic input_stage_bias_raise;
      logic input_stage_bias_lower;
      logic input_buffer_bypass_force;
      logic input_buffer_ground_force;
      logic ref_high_ohm_ground_force;
      logic ref_mid_ohm_ground_force;
      logic ref_low_ohm_ground_force;
   } ctb_bias_s;

   // one channel's level controller readouts
   typedef struct packed {
      logic       on;
      logic [8:0] p2p;
      logic [8:0] peak;
   } ctb_alc_s;

endpackage : ctb_pkg

// ---- src/ctb_irq.sv ----
// sticky event status, mask and level interrupt output
`timescale 1ns/10ps
module ctb_irq (
   input  wire logic                      clk_i,
   input  wire logic                      rst_i,
   input  wire logic [ctb_pkg::EV_W-1:0]  event_i,
   input  wire logic                      clr_wr_i,
   input  wire logic                      mask_wr_i,
   input  wire logic [ctb_pkg::EV_W-1:0]  wr_data_i,
   output logic      [ctb_pkg::EV_W-1:0]  status_o,
   output logic      [ctb_pkg::EV_W-1:0]  mask_o,
   output logic                           irq_o
);

   logic [ctb_pkg::EV_W-1:0] status_q;
   logic [ctb_pkg::EV_W-1:0] status_d;
   logic [ctb_pkg::EV_W-1:0] mask_q;

   // a new event beats a write-one-to-clear in the same cycle
   always_comb begin
      status_d = status_q;
      if (clr_wr_i) begin
         status_d = status_d & ~wr_data_i;
      end
      status_d = status_d | event_i;
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         status_q <= ctb_pkg::STAT_RST;
      end else begin
         status_q <= status_d;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         mask_q <= ctb_pkg::MASK_RST;
      end else if (mask_wr_i) begin
         mask_q <= wr_data_i;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         irq_o <= 1'b0;
      end else begin
         irq_o <= |(status_d & mask_q);
      end
   end

   assign status_o = status_q;
   assign mask_o   = mask_q;

endmodule : ctb_irq

// ---- verif/ctb_regs_tb_top.sv ----
// self-checking bench for the tie-off, bias, readout and status register slice
`timescale 1ns/10ps
module ctb_regs_tb_top;
   logic              clk_i    = 1'b0;
   logic              rst_i    = 1'b1;
   logic              wb_cyc_i = 1'b0;
   logic              wb_stb_i = 1'b0;
   logic              wb_we_i  = 1'b0;
   logic [9:0]        wb_adr_i = 10'h000;
   logic [3:0]        wb_sel_i = 4'h0;
   logic [31:0]       wb_dat_i = 32'h0000_0000;
   logic [31:0]       wb_dat_o;
   logic              wb_ack_o;
   ctb_pkg::ctb_alc_s alc_l    = '0;
   ctb_pkg::ctb_alc_s alc_r    = '0;
   logic              gate     = 1'b0;
   logic              hv       = 1'b0;
   logic [2:0]        auto_tie = 3'h0;
   logic              buf_en   = 1'b0;
   logic [1:0]        auto_buf = 2'h0;
   logic [2:0]        pm_ref   = 3'h0;
   logic [2:0]        tie_o;
   logic [2:0]        trim_o;
   logic [1:0]        buf_o;
   logic [2:0]        ref_o;
   logic              amute_o;
   logic              irq_o;
   int                bad_count = 0;
   int                cmp_count = 0;
   int                cyc_n     = 0;
   logic [31:0]       rd;
   logic [8:0]        w;
   logic [8:0]        v;

   always #2.5 clk_i = ~clk_i;

   ctb_regs uut (
      .clk_i                      (clk_i),
      .rst_i                      (rst_i),
      .wb_cyc_i                   (wb_cyc_i),
      .wb_stb_i                   (wb_stb_i),
      .wb_we_i                    (wb_we_i),
      .wb_adr_i                   (wb_adr_i),
      .wb_sel_i                   (wb_sel_i),
      .wb_dat_i                   (wb_dat_i),
      .wb_dat_o                   (wb_dat_o),
      .wb_ack_o                   (wb_ack_o),
      .alc_left_i                 (alc_l),
      .alc_right_i                (alc_r),
      .noise_gate_active_flag_i   (gate),
      .speaker_supply_high_flag_i (hv),
      .auto_left_line_tieoff_i    (auto_tie[2]),
      .auto_left_inv_tieoff_i     (auto_tie[1]),
      .auto_left_noninv_tieoff_i  (auto_tie[0]),
      .input_buffer_enabled_i     (buf_en),
      .auto_buffer_bypass_i       (auto_buf[1]),
      .auto_buffer_ground_i       (auto_buf[0]),
      .pm_ref_ground_i            (pm_ref),
      .left_line_tieoff_o         (tie_o[2]),
      .left_inv_tieoff_o          (tie_o[1]),
      .left_noninv_tieoff_o       (tie_o[0]),
      .input_stage_bias_half_o    (trim_o[2]),
      .input_stage_bias_raise_o   (trim_o[1]),
      .input_stage_bias_lower_o   (trim_o[0]),
      .input_buffer_bypass_o      (buf_o[1]),
      .input_buffer_ground_o      (buf_o[0]),
      .ref_ground_o               (ref_o),
      .automute_source_select_o   (amute_o),
      .irq_o                      (irq_o)
   );

   task automatic end_of_test();
      $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
      if (bad_count == 0 && cmp_count > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask : end_of_test

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         bad_count++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   // one classic cycle; holds the request until ack is sampled high
   task automatic xfer(input logic we, input logic [7:0] idx, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk_i);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i  <= we;
      wb_adr_i <= {idx, 2'b00};
      wb_sel_i <= 4'h3;
      wb_dat_i <= d;
      do begin
         @(posedge clk_i);
         n++;
      end while (wb_ack_o !== 1'b1 && n < 50);
      rd = wb_dat_o;
      if (n >= 50) begin
         bad_count++;
         $display("CHECK FAILED at %0t: no acknowledge", $time);
      end
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      wb_we_i  <= 1'b0;
   endtask : xfer

   task automatic rnd_in();
      @(posedge clk_i);
      auto_tie <= 3'($urandom);
      buf_en   <= 1'($urandom);
      auto_buf <= 2'($urandom);
      pm_ref   <= 3'($urandom);
      alc_l    <= 19'($urandom);
      alc_r    <= 19'($urandom);
   endtask : rnd_in

   // expected {tie-offs, bias trims, buffer switches, reference switches}
   function automatic logic [10:0] exp_out(input logic [8:0] t, input logic [8:0] b);
      ctb_pkg::ctb_tie_s ts;
      logic [2:0]        tie;
      ts  = t;
      tie = ts.input_tieoff_override_enable ? t[2:0] : auto_tie;
      return {tie, b[8], b[6:5], (b[4:3] & {2{~buf_en}}) | auto_buf, b[2:0] | pm_ref};
   endfunction : exp_out

   function automatic logic [31:0] exp_lvl(input logic pk);
      logic [8:0] l;
      logic [8:0] r;
      l = pk ? alc_l.peak : alc_l.p2p;
      r = pk ? alc_r.peak : alc_r.p2p;
      if (alc_l.on && alc_r.on) return {23'h0, (l > r) ? l : r};
      return {23'h0, (alc_r.on && !alc_l.on) ? r : l};
   endfunction : exp_lvl

   always @(posedge clk_i) begin
      cyc_n++;
      if (cyc_n == 20000) begin
         bad_count++;
         $display("CHECK FAILED at %0t: timeout", $time);
         end_of_test();
      end
   end

   initial begin
      void'($urandom(32'h0000_cef1));
      repeat (16) @(posedge clk_i);
      rst_i <= 1'b0;
      for (int i = 0; i < 9; i++) begin
         xfer(1'b0, 8'h4a + 8'(i % 5), 32'h0000_0000);
         chk(rd, 32'h0000_0000);
      end
      $display("test reset values done");
      for (int i = 0; i < 24; i++) begin
         rnd_in();
         w = (i == 0) ? 9'h1ff : (i == 1) ? 9'h0ff : 9'($urandom);
         v = (i == 0) ? 9'h1ff : 9'($urandom);
         xfer(1'b1, ctb_pkg::IDX_TIEOFF, {23'h0, w});
         xfer(1'b1, ctb_pkg::IDX_BIAS, {23'h0, v});
         xfer(1'b0, ctb_pkg::IDX_TIEOFF, 32'h0000_0000);
         chk(rd, {23'h0, w & ctb_pkg::TIE_WR_MASK});
         xfer(1'b0, ctb_pkg::IDX_BIAS, 32'h0000_0000);
         chk(rd, {23'h0, v & ctb_pkg::BIAS_WR_MASK});
         repeat (2) @(posedge clk_i);
         chk({21'h0, tie_o, trim_o, buf_o, ref_o}, {21'h0, exp_out(w, v)});
      end
      $display("test tie-off and bias done");
      for (int i = 0; i < 16; i++) begin
         rnd_in();
         xfer(1'b1, ctb_pkg::IDX_P2P, $urandom);
         xfer(1'b1, ctb_pkg::IDX_PEAK, $urandom);
         xfer(1'b0, ctb_pkg::IDX_P2P, 32'h0000_0000);
         chk(rd, exp_lvl(1'b0));
         xfer(1'b0, ctb_pkg::IDX_PEAK, 32'h0000_0000);
         chk(rd, exp_lvl(1'b1));
      end
      $display("test level readouts done");
      for (int i = 0; i < 8; i++) begin
         @(posedge clk_i);
         hv   <= 1'($urandom);
         gate <= 1'($urandom);
         w = 9'($urandom);
         xfer(1'b1, ctb_pkg::IDX_AMUTE, {23'h0, w});
         repeat (4) @(posedge clk_i);
         xfer(1'b0, ctb_pkg::IDX_AMUTE, 32'h0000_0000);
         chk(rd, {26'h0, w[5], hv, gate, 3'h0});
         chk({31'h0, amute_o}, {31'h0, w[5]});
      end
      xfer(1'b1, 8'h4f, 32'h0000_01ff);
      xfer(1'b0, 8'h4f, 32'h0000_0000);
      chk(rd, 32'h0000_0000);
      $display("test automute and unmapped done");
      @(posedge clk_i);
      hv   <= 1'b0;
      gate <= 1'b0;
      repeat (6) @(posedge clk_i);
      xfer(1'b1, ctb_pkg::IDX_IRQ_MASK, 32'h0000_0000);
      xfer(1'b1, ctb_pkg::IDX_IRQ_STAT, 32'h0000_000f);
      xfer(1'b0, ctb_pkg::IDX_IRQ_STAT, 32'h0000_0000);
      chk(rd, 32'h0000_0000);
      gate <= 1'b1;
      repeat (3) @(posedge clk_i);
      xfer(1'b0, ctb_pkg::IDX_IRQ_STAT, 32'h0000_0000);
      chk(rd, 32'h0000_0004);
      chk({31'h0, irq_o}, 32'h0000_0000);
      xfer(1'b1, ctb_pkg::IDX_IRQ_MASK, 32'h0000_0004);
      repeat (2) @(posedge clk_i);
      chk({31'h0, irq_o}, 32'h0000_0001);
      xfer(1'b1, ctb_pkg::IDX_IRQ_STAT, 32'h0000_0004);
      repeat (2) @(posedge clk_i);
      chk({31'h0, irq_o}, 32'h0000_0000);
      hv   <= 1'b1;
      gate <= 1'b0;
      repeat (6) @(posedge clk_i);
      xfer(1'b0, ctb_pkg::IDX_IRQ_STAT, 32'h0000_0000);
      chk(rd, 32'h0000_0009);
      chk({31'h0, irq_o}, 32'h0000_0000);
      xfer(1'b1, ctb_pkg::IDX_IRQ_MASK, 32'h0000_0001);
      repeat (2) @(posedge clk_i);
      chk({31'h0, irq_o}, 32'h0000_0001);
      $display("test interrupts done");
      end_of_test();
   end
endmodule : ctb_regs_tb_top
